// >>> hw/xb_params.svh
// Constants for the fixed-priority crossbar arbiter
`ifndef XB_PARAMS_SVH
`define XB_PARAMS_SVH

// Memory controller source slots, highest priority first
`define XB_MEM_SRCS 4
`define XB_MEM_SLOTS 3
`define XB_SLOT_SHARED 0
`define XB_SLOT_DATA_A 1
`define XB_SLOT_DATA_B 2
`define XB_SLOT_FETCH 3

// Host window: one 64 KB page, selected by the upper address bits
`define XB_ADDR_W 32
`define XB_PAGE_BYTES 65536
`define XB_PAGE_LSB 16
`define XB_PAGE_W 16
`define XB_PAGE_RST 16'h0000

// Peripheral system clock as a divided enable of the core system clock
`define XB_PER_DIV 2
`define XB_DIV_W 4

`endif

// >>> hw/xb_pkg.sv
// Types shared by the crossbar arbiter files
package xb_pkg;

   // Owner of the shared 32-bit memory port
   typedef enum logic [1:0] {
      XB_OWN_NONE = 2'h0,
      XB_OWN_ACC = 2'h1,
      XB_OWN_HOST = 2'h3
   } xb_owner_type;

endpackage

// >>> hw/xb_fixed_pick.sv
// Fixed-priority picker granting up to a number of lowest-index requests
`timescale 1ns/1ps
`default_nettype none

module xb_fixed_pick #(
   parameter int N = 4,
   parameter int K = 3
) (
   input wire logic [N-1:0] req,
   output logic [N-1:0] gnt
);
   import xb_pkg::*;

   // Running count of requests ahead of each position
   logic [7:0] ahead [0:N];

   assign ahead[0] = 8'h00;

   // Each position wins when fewer than K requests stand ahead of it
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_pos
         assign ahead[i+1] = ahead[i] + {7'h00, req[i]};
         assign gnt[i] = req[i] && (ahead[i] < 8'(K));
      end
   endgenerate

endmodule
`default_nettype wire

// >>> hw/xb_crossbar_arb.sv
// Crossbar arbiter: three masters, memory and peripheral targets
`timescale 1ns/1ps
`default_nettype none
`include "xb_params.svh"

// Notes on behaviour
// - Masters on different targets proceed together
// - Conflicts resolved by fixed priority only
// - Accelerator first, host second, core last
// - No host path to peripherals; refused
// - Memory serves three of four sources
// - Core data access completes in one cycle
// - Host confined to core-selected 64 KB page
// - Peripheral side runs on divided system clock
module xb_crossbar_arb #(
   parameter int PER_DIV = `XB_PER_DIV
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cpu_da_req,
   input wire logic cpu_db_req,
   input wire logic fetch_req,
   input wire logic cpu_per_req,
   input wire logic acc_mem_req,
   input wire logic acc_per_req,
   input wire logic host_mem_req,
   input wire logic host_per_req,
   input wire logic [`XB_ADDR_W-1:0] host_addr,
   input wire logic host_restrict_en,
   input wire logic core_page_wr,
   input wire logic [`XB_PAGE_W-1:0] core_page_sel,
   input wire logic per_ready,
   output logic cpu_da_gnt,
   output logic cpu_db_gnt,
   output logic fetch_gnt,
   output logic acc_mem_gnt,
   output logic host_mem_gnt,
   output logic cpu_per_gnt,
   output logic acc_per_gnt,
   output logic host_err,
   output logic per_tick,
   output xb_pkg::xb_owner_type shared_owner
);
   import xb_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   logic [`XB_PAGE_W-1:0] page_r, page_nxt;
   logic [`XB_DIV_W-1:0] div_r, div_nxt;
   logic tick_r, tick_nxt;
   logic [`XB_MEM_SRCS-1:0] mgnt_r, mgnt_nxt;
   logic own_acc_r, own_acc_nxt;
   logic own_host_r, own_host_nxt;
   logic cpu_per_r, cpu_per_nxt;
   logic acc_per_r, acc_per_nxt;
   logic err_r, err_nxt;
   xb_owner_type owner_r, owner_nxt;

   // ****************************************************
   // Eligibility
   // ****************************************************
   logic host_in_page;
   logic acc_m, host_m, da_m, db_m, fe_m, acc_p, cpu_p;
   logic [`XB_MEM_SRCS-1:0] mreq, mpick;

   // Host address must fall in the selected page when restricted
   assign host_in_page = !host_restrict_en ||
      (host_addr[`XB_ADDR_W-1:`XB_PAGE_LSB] == page_r);

   // A request whose grant shows this cycle is already served
   assign acc_m = acc_mem_req && !own_acc_r;
   assign host_m = host_mem_req && !own_host_r && host_in_page;
   assign da_m = cpu_da_req && !mgnt_r[`XB_SLOT_DATA_A];
   assign db_m = cpu_db_req && !mgnt_r[`XB_SLOT_DATA_B];
   assign fe_m = fetch_req && !mgnt_r[`XB_SLOT_FETCH];
   assign acc_p = acc_per_req && !acc_per_r;
   assign cpu_p = cpu_per_req && !cpu_per_r;

   // Shared port is requested by either accelerator or host
   assign mreq[`XB_SLOT_SHARED] = acc_m || host_m;
   assign mreq[`XB_SLOT_DATA_A] = da_m;
   assign mreq[`XB_SLOT_DATA_B] = db_m;
   assign mreq[`XB_SLOT_FETCH] = fe_m;

   // Up to three memory sources per cycle, fixed order
   xb_fixed_pick #(
      .N(`XB_MEM_SRCS),
      .K(`XB_MEM_SLOTS)
   ) u_mem_pick (
      .req(mreq),
      .gnt(mpick)
   );

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      page_nxt = page_r;
      div_nxt = div_r;
      tick_nxt = 1'b0;
      mgnt_nxt = mpick;
      own_acc_nxt = 1'b0;
      own_host_nxt = 1'b0;
      cpu_per_nxt = 1'b0;
      acc_per_nxt = 1'b0;
      err_nxt = 1'b0;
      owner_nxt = XB_OWN_NONE;
      // Only the core may move the host page
      if (core_page_wr) begin
         page_nxt = core_page_sel;
      end
      // Peripheral side advances once per divided period
      if (div_r == `XB_DIV_W'(PER_DIV - 1)) begin
         div_nxt = '0;
         tick_nxt = 1'b1;
      end else begin
         div_nxt = div_r + `XB_DIV_W'(1);
      end
      // Accelerator wins the shared port over the host
      if (mpick[`XB_SLOT_SHARED]) begin
         if (acc_m) begin
            own_acc_nxt = 1'b1;
            owner_nxt = XB_OWN_ACC;
         end else begin
            own_host_nxt = 1'b1;
            owner_nxt = XB_OWN_HOST;
         end
      end
      // Peripheral target: accelerator over core, on the tick only
      if (tick_r && per_ready) begin
         if (acc_p) begin
            acc_per_nxt = 1'b1;
         end else if (cpu_p) begin
            cpu_per_nxt = 1'b1;
         end
      end
      // Host has no route to peripherals, nor outside its page
      if (host_per_req || (host_mem_req && !host_in_page)) begin
         err_nxt = 1'b1;
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         page_r <= `XB_PAGE_RST;
         div_r <= '0;
         tick_r <= 1'b0;
         mgnt_r <= '0;
         own_acc_r <= 1'b0;
         own_host_r <= 1'b0;
         cpu_per_r <= 1'b0;
         acc_per_r <= 1'b0;
         err_r <= 1'b0;
         owner_r <= XB_OWN_NONE;
      end else if (ce) begin
         page_r <= page_nxt;
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         mgnt_r <= mgnt_nxt;
         own_acc_r <= own_acc_nxt;
         own_host_r <= own_host_nxt;
         cpu_per_r <= cpu_per_nxt;
         acc_per_r <= acc_per_nxt;
         err_r <= err_nxt;
         owner_r <= owner_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign cpu_da_gnt = mgnt_r[`XB_SLOT_DATA_A];
   assign cpu_db_gnt = mgnt_r[`XB_SLOT_DATA_B];
   assign fetch_gnt = mgnt_r[`XB_SLOT_FETCH];
   assign acc_mem_gnt = own_acc_r;
   assign host_mem_gnt = own_host_r;
   assign cpu_per_gnt = cpu_per_r;
   assign acc_per_gnt = acc_per_r;
   assign host_err = err_r;
   assign per_tick = tick_r;
   assign shared_owner = owner_r;

   // ****************************************************
   // Assertions
   // ****************************************************
   // Shared port and both data ports served together
   property p_parallel;
      @(posedge core_clk) disable iff (rst)
      ce && acc_m && da_m && db_m |=>
         acc_mem_gnt && cpu_da_gnt && cpu_db_gnt;
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("parallel grants not given");

   property p_per_excl;
      @(posedge core_clk) disable iff (rst)
      !(acc_per_gnt && cpu_per_gnt);
   endproperty
   a_per_excl: assert property (p_per_excl)
      else $error("two peripheral grants at once");

   property p_acc_host;
      @(posedge core_clk) disable iff (rst)
      ce && acc_m && host_m |=> acc_mem_gnt && !host_mem_gnt;
   endproperty
   a_acc_host: assert property (p_acc_host)
      else $error("accelerator did not win shared port");

   property p_no_host_per;
      @(posedge core_clk) disable iff (rst)
      ce && host_per_req |=> host_err;
   endproperty
   a_no_host_per: assert property (p_no_host_per)
      else $error("host peripheral request not refused");

   property p_three;
      @(posedge core_clk) disable iff (rst)
      $countones(mgnt_r) <= `XB_MEM_SLOTS;
   endproperty
   a_three: assert property (p_three)
      else $error("more than three memory grants");

   property p_single;
      @(posedge core_clk) disable iff (rst)
      ce && da_m |=> cpu_da_gnt;
   endproperty
   a_single: assert property (p_single)
      else $error("core data access not served in one cycle");

   property p_page;
      @(posedge core_clk) disable iff (rst)
      ce && host_mem_req && host_restrict_en &&
      (host_addr[`XB_ADDR_W-1:`XB_PAGE_LSB] != page_r) |=>
         !host_mem_gnt && host_err;
   endproperty
   a_page: assert property (p_page)
      else $error("host reached outside its page");

   property p_tick;
      @(posedge core_clk) disable iff (rst)
      $rose(acc_per_gnt) || $rose(cpu_per_gnt) |-> $past(tick_r);
   endproperty
   a_tick: assert property (p_tick)
      else $error("peripheral grant off the peripheral tick");

   property p_wait;
      @(posedge core_clk) disable iff (rst)
      ce && acc_p && cpu_p |=> !cpu_per_gnt;
   endproperty
   a_wait: assert property (p_wait)
      else $error("core granted over accelerator");

   c_all_mem: cover property (@(posedge core_clk) disable iff (rst)
      $countones(mgnt_r) == `XB_MEM_SLOTS);
   c_host_mem: cover property (@(posedge core_clk) disable iff (rst)
      host_mem_gnt);
   c_acc_per: cover property (@(posedge core_clk) disable iff (rst)
      acc_per_gnt && acc_mem_gnt);
   c_err: cover property (@(posedge core_clk) disable iff (rst) host_err);

endmodule
`default_nettype wire

// >>> sim/xb_per_model.sv
// Peripheral target model that answers promptly or stays busy
`timescale 1ns/1ps
`default_nettype none

module xb_per_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic cpu_per_gnt,
   input wire logic acc_per_gnt,
   output logic per_ready
);
   logic [2:0] busy_r;
   logic [2:0] busy_nxt;

   // Slow mode stays busy for five cycles after each access
   always_comb begin
      busy_nxt = busy_r;
      if ((cpu_per_gnt | acc_per_gnt) & slow) begin
         busy_nxt = 3'h5;
      end else if (busy_r != 3'h0) begin
         busy_nxt = busy_r - 3'h1;
      end
   end

   // Register the busy count
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy_r <= 3'h0;
      end else begin
         busy_r <= busy_nxt;
      end
   end

   assign per_ready = (busy_r == 3'h0);
endmodule

`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the fixed-priority crossbar arbiter
`timescale 1ns/1ps
`default_nettype none

module tb;
   import xb_pkg::*;
   localparam int PD = 2;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic slow = 1'b0;
   logic [4:0] mreq = 5'h00;
   logic cpu_per_req = 1'b0;
   logic acc_per_req = 1'b0;
   logic host_per_req = 1'b0;
   logic [31:0] host_addr = 32'h00000000;
   logic restrict_en = 1'b0;
   logic page_wr = 1'b0;
   logic [15:0] page_sel = 16'h0000;
   wire logic per_ready;
   logic [4:0] mg;
   logic [1:0] pg;
   logic host_err;
   logic per_tick;
   logic pt;
   xb_owner_type shared_owner;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int k;
   // Row: requests, grants (acc,host,da,db,fetch), owner
   logic [11:0] rows [7] = '{12'hFD9, 12'h7BB, 12'h39C, 12'h8C5,
      12'h5AF, 12'hF59, 12'h000};

   always #4 core_clk = ~core_clk;

   xb_crossbar_arb #(.PER_DIV(PD)) dut (
      .core_clk(core_clk), .rst(rst), .ce(ce),
      .cpu_da_req(mreq[2]), .cpu_db_req(mreq[1]), .fetch_req(mreq[0]),
      .cpu_per_req(cpu_per_req), .acc_mem_req(mreq[4]),
      .acc_per_req(acc_per_req), .host_mem_req(mreq[3]),
      .host_per_req(host_per_req), .host_addr(host_addr),
      .host_restrict_en(restrict_en), .core_page_wr(page_wr),
      .core_page_sel(page_sel), .per_ready(per_ready),
      .cpu_da_gnt(mg[2]), .cpu_db_gnt(mg[1]), .fetch_gnt(mg[0]),
      .acc_mem_gnt(mg[4]), .host_mem_gnt(mg[3]), .cpu_per_gnt(pg[0]),
      .acc_per_gnt(pg[1]), .host_err(host_err), .per_tick(per_tick),
      .shared_owner(shared_owner)
   );

   xb_per_model peer (
      .core_clk(core_clk), .rst(rst), .slow(slow),
      .cpu_per_gnt(pg[0]), .acc_per_gnt(pg[1]), .per_ready(per_ready)
   );

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // One-cycle memory request, grants checked in the answer cycle
   task automatic mem_case(input logic [11:0] r, input logic e);
      @(posedge core_clk) mreq <= r[11:7];
      @(posedge core_clk) mreq <= 5'h00;
      #1;
      chk(mg === r[6:2] && shared_owner === xb_owner_type'(r[1:0])
         && host_err === e, "memory grant");
      @(posedge core_clk);
   endtask

   // Bounded wait for a peripheral grant
   task automatic wait_pg(input int s);
      k = 0;
      while (pg[s] !== 1'b1 && k < 20) begin
         @(posedge core_clk);
         #1;
         k++;
      end
   endtask

   task automatic stop_test();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         stop_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk({mg, pg, host_err} === 8'h00 && shared_owner === XB_OWN_NONE,
         "reset");
      k = 0;
      // Sample the tick once it has settled after each edge
      repeat (8) begin
         @(posedge core_clk);
         #1;
         k += (per_tick === 1'b1);
      end
      chk(k == 8 / PD, "tick rate");
      foreach (rows[i]) mem_case(rows[i], 1'b0);
      // Losers wait and are served in the next cycle
      @(posedge core_clk) mreq <= 5'h1F;
      @(posedge core_clk) mreq <= 5'h09;
      #1;
      chk(mg === 5'h16, "first round");
      @(posedge core_clk) begin
         mreq <= 5'h00;
         ce <= 1'b0;
      end
      #1;
      chk(mg === 5'h09, "waiting served");
      // Clock enable low freezes grants and the divider
      pt = per_tick;
      @(posedge core_clk) ce <= 1'b1;
      #1;
      chk(mg === 5'h09 && per_tick === pt, "clock enable hold");
      // Host window set by the core
      @(posedge core_clk) begin
         restrict_en <= 1'b1;
         page_wr <= 1'b1;
         page_sel <= 16'h1234;
      end
      @(posedge core_clk) begin
         page_wr <= 1'b0;
         host_addr <= 32'h12340010;
      end
      mem_case(12'h423, 1'b0);
      host_addr <= 32'h56780000;
      mem_case(12'h400, 1'b1);
      // Host to peripheral is refused
      @(posedge core_clk) host_per_req <= 1'b1;
      @(posedge core_clk) host_per_req <= 1'b0;
      #1;
      chk(host_err === 1'b1 && pg === 2'h0, "host peripheral");
      // Peripheral conflict with a slow target
      @(posedge core_clk) begin
         slow <= 1'b1;
         acc_per_req <= 1'b1;
         cpu_per_req <= 1'b1;
      end
      wait_pg(1);
      chk(pg === 2'h2, "accelerator first");
      @(posedge core_clk) acc_per_req <= 1'b0;
      wait_pg(0);
      chk(pg === 2'h1, "core served later");
      @(posedge core_clk) cpu_per_req <= 1'b0;
      stop_test();
   end
endmodule

`default_nettype wire
